// ---- pifs_regs.svh ----
`ifndef PIFS_REGS_SVH
`define PIFS_REGS_SVH

// Synchronised pin positions
`define PIFS_NPINS 16
`define PIFS_P_KEY 0
`define PIFS_P_SELF 1
`define PIFS_P_PMEM 2
`define PIFS_P_PHFB 3
`define PIFS_P_CPROT 4
`define PIFS_P_PHLO 5
`define PIFS_P_PHHI 6
`define PIFS_P_DIODE 7
`define PIFS_P_CURNZ 8
`define PIFS_P_SEAT 9
`define PIFS_P_CAPCH 10
`define PIFS_P_CAPDIS 11
`define PIFS_P_COILLO 12
`define PIFS_P_MCCL 13
`define PIFS_P_ENA 14
`define PIFS_P_REQ 15

// Alarm bit positions, code is position plus one
`define PIFS_NALM 18
`define PIFS_CODE_W 5
`define PIFS_A_SELF 0
`define PIFS_A_PMEM 1
`define PIFS_A_SUPPLY 2
`define PIFS_A_PHFB 3
`define PIFS_A_CPROT 4
`define PIFS_A_BADSTART 5
`define PIFS_A_ENC 6
`define PIFS_A_CAPCH 7
`define PIFS_A_PHLO 8
`define PIFS_A_PHHI 9
`define PIFS_A_POTOFS 10
`define PIFS_A_POTWIRE 11
`define PIFS_A_STBYCUR 12
`define PIFS_A_SEAT 13
`define PIFS_A_DRVSHORT 14
`define PIFS_A_COILDRV 15
`define PIFS_A_MCOPEN 16
`define PIFS_A_MCWELD 17
// Alarms that drop once their condition is gone
`define PIFS_LIVE_MASK 18'h02c20
// Alarms that open the main contactor
`define PIFS_OPEN_MASK 18'h3d39c
// Alarms that stop all operation
`define PIFS_INH_MASK 18'h3dbbf

// Supply trip levels in volts per nominal battery
`define PIFS_NOM_48 2'h0
`define PIFS_NOM_80 2'h1
`define PIFS_NOM_96 2'h2
`define PIFS_NOM_120 2'h3
`define PIFS_UV_48 8'h0f
`define PIFS_OV_48 8'h41
`define PIFS_UV_80 8'h1e
`define PIFS_OV_80 8'h73
`define PIFS_UV_96 8'h22
`define PIFS_OV_96 8'h7d
`define PIFS_UV_120 8'h28
`define PIFS_OV_120 8'h98

// Encoder step limit in Hz, pot offset in mV
`define PIFS_ENC_MAX_STEP 12'h028
`define PIFS_POT_OFS_MV 13'h03e8

// Timing
`define PIFS_CLK_NS 32'h4
`define PIFS_NS_PER_MS 32'hf4240
`define PIFS_DISCH_TMO_MS 32'h64
`define PIFS_PRECH_TMO_MS 32'hc8
`define PIFS_COIL_TMO_MS 32'ha
`define PIFS_CLOSE_TMO_MS 32'h64

`endif

// ---- pifs_pkg.sv ----
package pifs_pkg;
  `include "pifs_regs.svh"

  typedef enum logic [3:0] {
    ST_OFF, ST_COILCHK, ST_DISCH, ST_PRECH, ST_DIAG,
    ST_DRIVE, ST_CLOSE, ST_STBY, ST_RUN, ST_HALT
  } pifs_st_t;

  typedef struct packed {
    logic [`PIFS_NALM-1:0] alarm;
    logic [`PIFS_CODE_W-1:0] code;
  } pifs_bank_t;

  typedef struct packed {
    logic [`PIFS_NPINS-1:0] s1;
    logic [`PIFS_NPINS-1:0] s2;
    pifs_st_t st;
    logic [31:0] cnt;
    logic [11:0] prev_spd;
    logic have_prev;
    logic pm_seen;
    logic restore;
  } pifs_main_t;
endpackage : pifs_pkg

// ---- pifs_alarm_bank.sv ----
`timescale 1ns/1ps
`include "pifs_regs.svh"
module pifs_alarm_bank (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [`PIFS_NALM-1:0] i_set,
  input wire logic [`PIFS_NALM-1:0] i_live,
  input wire logic i_clr_all,
  output logic [`PIFS_NALM-1:0] o_alarm,
  output logic [`PIFS_CODE_W-1:0] o_code
);
  pifs_pkg::pifs_bank_t r_r;
  pifs_pkg::pifs_bank_t r_nxt;
  logic [`PIFS_NALM-1:0] hold;
  localparam logic [`PIFS_NALM-1:0] LIVE = `PIFS_LIVE_MASK;

  // Set wins over every clear
  genvar g;
  generate
    for (g = 0; g < `PIFS_NALM; g = g + 1) begin : g_bit
      assign hold[g] = i_set[g] |
        (~i_clr_all & r_r.alarm[g] & (~LIVE[g] | i_live[g]));
    end
  endgenerate

  always_comb begin
    r_nxt = r_r;
    r_nxt.alarm = hold;
    r_nxt.code = '0;
    for (int i = `PIFS_NALM - 1; i >= 0; i--) begin
      if (hold[i]) begin
        r_nxt.code = 5'(i + 1);
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_alarm = r_r.alarm;
  assign o_code = r_r.code;
endmodule : pifs_alarm_bank

// ---- pifs_supervisor.sv ----
// What this block does
// - Self-test failure in standby or running raises the self-test alarm.
// - Parameter memory fault inhibits operation; recovery after key cycle restores defaults.
// - Supply trip raises alarm, stops operation, opens contactor; clears on key cycle.
// - 36/48 V battery trips below 15 V or above 65 V.
// - 80 V battery trips below 30 V or above 115 V.
// - 96 V battery trips below 34 V or above 125 V.
// - 120 V battery trips below 40 V or above 152 V.
// - Phase feedback hardware fault alarms, stops operation, opens contactor.
// - Current protection hardware fault alarms, stops operation, opens contactor.
// - Inputs out of the required start order raise the incorrect-start alarm.
// - Encoder speed step above 40 Hz alarms and stops the power bridge.
// - Precharge bank at key-on within timeout, else alarm; skipped if charged.
// - Phase near ground or battery alarms, opens contactor, stops controller.
// - Pot above learned minimum plus 1 V alarms; pump requests ignored.
// - Pot return diode off raises wire alarm and blocks operation.
// - Non-zero standby current alarms, opens contactor, inhibits operation.
// - Seat readings of pump and traction differ in combi mode: seat alarm.
// - Combi leaves contactor to traction; standalone contactor alarms stop all.
// - Coil pin at zero before driving raises shorted-driver alarm, contactor open.
// - Coil pin not low after drive raises coil-driver alarm, all stopped.
// - Coil driven but contactor open raises contactor-open alarm.
// - Bank not discharging before drive raises welded alarm; skipped if discharged.
`timescale 1ns/1ps
`include "pifs_regs.svh"
module pifs_supervisor #(
  parameter int unsigned DISCH_TMO_CYC =
    `PIFS_DISCH_TMO_MS * `PIFS_NS_PER_MS / `PIFS_CLK_NS,
  parameter int unsigned PRECH_TMO_CYC =
    `PIFS_PRECH_TMO_MS * `PIFS_NS_PER_MS / `PIFS_CLK_NS,
  parameter int unsigned COIL_TMO_CYC =
    `PIFS_COIL_TMO_MS * `PIFS_NS_PER_MS / `PIFS_CLK_NS,
  parameter int unsigned CLOSE_TMO_CYC =
    `PIFS_CLOSE_TMO_MS * `PIFS_NS_PER_MS / `PIFS_CLK_NS
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_key_on,
  input wire logic i_selftest_fail,
  input wire logic i_param_mem_fault,
  input wire logic i_phase_fb_fault,
  input wire logic i_curr_prot_fault,
  input wire logic i_phase_voltage_low,
  input wire logic i_phase_voltage_high,
  input wire logic i_pot_return_diode_on,
  input wire logic i_motor_curr_nonzero,
  input wire logic i_seat_sw,
  input wire logic i_cap_charged,
  input wire logic i_cap_discharged,
  input wire logic i_contactor_coil_drive_pin_low,
  input wire logic i_main_contactor_closed,
  input wire logic i_pump_enable_sw,
  input wire logic i_pump_req,
  input wire logic i_combi_mode,
  input wire logic i_seat_remote,
  input wire logic [1:0] i_batt_nominal,
  input wire logic [7:0] i_batt_volt,
  input wire logic i_enc_valid,
  input wire logic [11:0] i_enc_speed,
  input wire logic [11:0] i_pot_mv,
  input wire logic [11:0] i_pot_minimum_learn_mv,
  output logic o_coil_drive,
  output logic o_discharge_en,
  output logic o_precharge_en,
  output logic o_bridge_en,
  output logic o_pump_ignore,
  output logic o_run_inhibit,
  output logic o_restore_defaults,
  output logic [`PIFS_NALM-1:0] o_alarm,
  output logic [`PIFS_CODE_W-1:0] o_alarm_code
);
  pifs_pkg::pifs_main_t r_r;
  pifs_pkg::pifs_main_t r_nxt;
  logic [`PIFS_NPINS-1:0] pins_in;
  logic [`PIFS_NPINS-1:0] p;
  logic [`PIFS_NALM-1:0] alm_set;
  logic [`PIFS_NALM-1:0] alm_live;
  logic [`PIFS_NALM-1:0] alarm;
  logic clr_all;
  logic on;
  logic open_contactor;
  logic inhibit;
  logic [7:0] uv_lvl;
  logic [7:0] ov_lvl;
  logic [11:0] spd_step;
  logic pot_high;

  assign pins_in = {i_pump_req, i_pump_enable_sw, i_main_contactor_closed,
    i_contactor_coil_drive_pin_low, i_cap_discharged, i_cap_charged,
    i_seat_sw, i_motor_curr_nonzero, i_pot_return_diode_on,
    i_phase_voltage_high, i_phase_voltage_low, i_curr_prot_fault,
    i_phase_fb_fault, i_param_mem_fault, i_selftest_fail, i_key_on};
  assign p = r_r.s2;
  assign on = (r_r.st != pifs_pkg::ST_OFF);
  assign clr_all = ~on;
  assign open_contactor = |(alarm & `PIFS_OPEN_MASK);
  assign inhibit = |(alarm & `PIFS_INH_MASK);
  assign spd_step = (i_enc_speed > r_r.prev_spd) ? i_enc_speed - r_r.prev_spd
                                                 : r_r.prev_spd - i_enc_speed;
  assign pot_high = {1'b0, i_pot_mv} >
    ({1'b0, i_pot_minimum_learn_mv} + `PIFS_POT_OFS_MV);

  always_comb begin
    case (i_batt_nominal)
      `PIFS_NOM_48: begin
        uv_lvl = `PIFS_UV_48;
        ov_lvl = `PIFS_OV_48;
      end
      `PIFS_NOM_80: begin
        uv_lvl = `PIFS_UV_80;
        ov_lvl = `PIFS_OV_80;
      end
      `PIFS_NOM_96: begin
        uv_lvl = `PIFS_UV_96;
        ov_lvl = `PIFS_OV_96;
      end
      default: begin
        uv_lvl = `PIFS_UV_120;
        ov_lvl = `PIFS_OV_120;
      end
    endcase
  end
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = pins_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.restore = 1'b0;
    alm_set = '0;
    alm_live = '0;
    alm_live[`PIFS_A_BADSTART] = p[`PIFS_P_REQ];
    alm_live[`PIFS_A_POTOFS] = pot_high;
    alm_live[`PIFS_A_POTWIRE] = ~p[`PIFS_P_DIODE];
    alm_live[`PIFS_A_SEAT] = p[`PIFS_P_SEAT] ^ i_seat_remote;
    if (on) begin
      alm_set[`PIFS_A_SELF] = p[`PIFS_P_SELF] &
        (r_r.st == pifs_pkg::ST_STBY || r_r.st == pifs_pkg::ST_RUN);
      alm_set[`PIFS_A_PMEM] = p[`PIFS_P_PMEM];
      alm_set[`PIFS_A_SUPPLY] = (i_batt_volt < uv_lvl) | (i_batt_volt > ov_lvl);
      alm_set[`PIFS_A_PHFB] = p[`PIFS_P_PHFB];
      alm_set[`PIFS_A_CPROT] = p[`PIFS_P_CPROT];
      alm_set[`PIFS_A_POTWIRE] = ~p[`PIFS_P_DIODE];
      alm_set[`PIFS_A_SEAT] = i_combi_mode & alm_live[`PIFS_A_SEAT];
      alm_set[`PIFS_A_ENC] = i_enc_valid & r_r.have_prev &
        (spd_step > `PIFS_ENC_MAX_STEP);
      if (r_r.st == pifs_pkg::ST_DIAG || r_r.st == pifs_pkg::ST_STBY) begin
        alm_set[`PIFS_A_PHLO] = p[`PIFS_P_PHLO];
        alm_set[`PIFS_A_PHHI] = p[`PIFS_P_PHHI];
      end
      if (r_r.st == pifs_pkg::ST_STBY) begin
        alm_set[`PIFS_A_BADSTART] = p[`PIFS_P_REQ] & ~p[`PIFS_P_ENA];
        alm_set[`PIFS_A_POTOFS] = ~p[`PIFS_P_ENA] & pot_high;
        alm_set[`PIFS_A_STBYCUR] = p[`PIFS_P_CURNZ];
      end
    end
    if (i_enc_valid) begin
      r_nxt.prev_spd = i_enc_speed;
      r_nxt.have_prev = on;
    end
    r_nxt.pm_seen = r_r.pm_seen | alarm[`PIFS_A_PMEM];
    r_nxt.cnt = r_r.cnt + 32'h1;
    case (r_r.st)
      pifs_pkg::ST_OFF: begin
        r_nxt.cnt = '0;
        r_nxt.have_prev = 1'b0;
        if (p[`PIFS_P_KEY]) begin
          r_nxt.st = pifs_pkg::ST_COILCHK;
          if (r_r.pm_seen && !p[`PIFS_P_PMEM]) begin
            r_nxt.restore = 1'b1;
            r_nxt.pm_seen = 1'b0;
          end
        end
      end
      pifs_pkg::ST_COILCHK: begin
        r_nxt.cnt = '0;
        if (i_combi_mode) begin
          r_nxt.st = pifs_pkg::ST_PRECH;
        end else if (p[`PIFS_P_COILLO]) begin
          alm_set[`PIFS_A_DRVSHORT] = 1'b1;
          r_nxt.st = pifs_pkg::ST_HALT;
        end else begin
          r_nxt.st = pifs_pkg::ST_DISCH;
        end
      end
      pifs_pkg::ST_DISCH: begin
        if (p[`PIFS_P_CAPDIS]) begin
          r_nxt.st = pifs_pkg::ST_PRECH;
          r_nxt.cnt = '0;
        end else if (r_r.cnt >= DISCH_TMO_CYC) begin
          alm_set[`PIFS_A_MCWELD] = 1'b1;
          r_nxt.st = pifs_pkg::ST_HALT;
        end
      end
      pifs_pkg::ST_PRECH: begin
        if (p[`PIFS_P_CAPCH]) begin
          r_nxt.st = pifs_pkg::ST_DIAG;
        end else if (r_r.cnt >= PRECH_TMO_CYC) begin
          alm_set[`PIFS_A_CAPCH] = 1'b1;
          r_nxt.st = pifs_pkg::ST_HALT;
        end
      end
      pifs_pkg::ST_DIAG: begin
        r_nxt.cnt = '0;
        if (inhibit || alm_set != '0) begin
          r_nxt.st = pifs_pkg::ST_HALT;
        end else if (i_combi_mode) begin
          r_nxt.st = pifs_pkg::ST_STBY;
        end else begin
          r_nxt.st = pifs_pkg::ST_DRIVE;
        end
      end
      pifs_pkg::ST_DRIVE: begin
        if (p[`PIFS_P_COILLO]) begin
          r_nxt.st = pifs_pkg::ST_CLOSE;
          r_nxt.cnt = '0;
        end else if (r_r.cnt >= COIL_TMO_CYC) begin
          alm_set[`PIFS_A_COILDRV] = 1'b1;
          r_nxt.st = pifs_pkg::ST_HALT;
        end
      end
      pifs_pkg::ST_CLOSE: begin
        if (p[`PIFS_P_MCCL]) begin
          r_nxt.st = pifs_pkg::ST_STBY;
        end else if (r_r.cnt >= CLOSE_TMO_CYC) begin
          alm_set[`PIFS_A_MCOPEN] = 1'b1;
          r_nxt.st = pifs_pkg::ST_HALT;
        end
      end
      pifs_pkg::ST_STBY: begin
        if (p[`PIFS_P_REQ] && p[`PIFS_P_ENA] && !inhibit &&
            !alarm[`PIFS_A_POTOFS] && alm_set == '0) begin
          r_nxt.st = pifs_pkg::ST_RUN;
        end
      end
      pifs_pkg::ST_RUN: begin
        if (!p[`PIFS_P_REQ] || !p[`PIFS_P_ENA] || inhibit) begin
          r_nxt.st = pifs_pkg::ST_STBY;
        end
      end
      pifs_pkg::ST_HALT: begin
        r_nxt.cnt = r_r.cnt;
      end
      default: begin
        r_nxt.st = pifs_pkg::ST_OFF;
      end
    endcase
    if (!p[`PIFS_P_KEY]) begin
      r_nxt.st = pifs_pkg::ST_OFF;
    end
  end
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
  pifs_alarm_bank u_bank (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_set(alm_set),
    .i_live(alm_live),
    .i_clr_all(clr_all),
    .o_alarm(alarm),
    .o_code(o_alarm_code)
  );
  assign o_alarm = alarm;
  assign o_coil_drive = ~i_combi_mode & ~open_contactor & (r_r.st == pifs_pkg::ST_DRIVE ||
    r_r.st == pifs_pkg::ST_CLOSE || r_r.st == pifs_pkg::ST_STBY ||
    r_r.st == pifs_pkg::ST_RUN);
  assign o_discharge_en = (r_r.st == pifs_pkg::ST_DISCH);
  assign o_precharge_en = (r_r.st == pifs_pkg::ST_PRECH);
  assign o_bridge_en = (r_r.st == pifs_pkg::ST_RUN) & ~inhibit &
    ~alarm[`PIFS_A_ENC];
  assign o_pump_ignore = alarm[`PIFS_A_POTOFS];
  assign o_run_inhibit = inhibit;
  assign o_restore_defaults = r_r.restore;
  sequence s_drive_timeout;
    r_r.st == pifs_pkg::ST_DRIVE && !p[`PIFS_P_COILLO] && r_r.cnt >= COIL_TMO_CYC;
  endsequence
  sequence s_prech_timeout;
    r_r.st == pifs_pkg::ST_PRECH && !p[`PIFS_P_CAPCH] && r_r.cnt >= PRECH_TMO_CYC;
  endsequence
  property p_enc_stop;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (on && p[`PIFS_P_KEY] && i_enc_valid && r_r.have_prev && spd_step > `PIFS_ENC_MAX_STEP)
      |=> alarm[`PIFS_A_ENC] && !o_bridge_en;
  endproperty
  a_enc_stop: assert property (p_enc_stop) else $error("bridge on with encoder alarm");
  property p_supply;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (on && p[`PIFS_P_KEY] && i_batt_nominal == `PIFS_NOM_80 && i_batt_volt < `PIFS_UV_80)
      |=> alarm[`PIFS_A_SUPPLY] && !o_coil_drive;
  endproperty
  a_supply: assert property (p_supply) else $error("undervoltage not caught");
  property p_phfb;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (alarm[`PIFS_A_PHFB] || alarm[`PIFS_A_CPROT]) |-> !o_coil_drive && !o_bridge_en;
  endproperty
  a_phfb: assert property (p_phfb) else $error("hardware fault left drive on");
  property p_drvshort;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (r_r.st == pifs_pkg::ST_COILCHK && !i_combi_mode && p[`PIFS_P_COILLO] &&
      p[`PIFS_P_KEY]) |=> alarm[`PIFS_A_DRVSHORT] ##1 !o_coil_drive[*3];
  endproperty
  a_drvshort: assert property (p_drvshort) else $error("shorted driver missed");
  property p_coildrv;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (s_drive_timeout and p[`PIFS_P_KEY]) |=> alarm[`PIFS_A_COILDRV] &&
      r_r.st == pifs_pkg::ST_HALT;
  endproperty
  a_coildrv: assert property (p_coildrv) else $error("coil driver timeout missed");
  property p_prech;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (s_prech_timeout and p[`PIFS_P_KEY]) |=> alarm[`PIFS_A_CAPCH] && !o_coil_drive;
  endproperty
  a_prech: assert property (p_prech) else $error("precharge timeout missed");
  property p_potofs;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (alarm[`PIFS_A_POTOFS] && r_r.st == pifs_pkg::ST_STBY) |=>
      r_r.st != pifs_pkg::ST_RUN;
  endproperty
  a_potofs: assert property (p_potofs) else $error("pump ran despite pot offset");
  property p_stbycur;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (r_r.st == pifs_pkg::ST_STBY && p[`PIFS_P_CURNZ]) |=>
      alarm[`PIFS_A_STBYCUR] && !o_coil_drive && o_run_inhibit;
  endproperty
  a_stbycur: assert property (p_stbycur) else $error("standby current missed");
  property p_pmem;
    @(posedge i_mclk) disable iff (i_sys_rst)
    alarm[`PIFS_A_PMEM] |-> o_run_inhibit && !o_bridge_en;
  endproperty
  a_pmem: assert property (p_pmem) else $error("memory fault not inhibiting");
  property p_code;
    @(posedge i_mclk) disable iff (i_sys_rst)
    (alarm != '0) == (o_alarm_code != '0);
  endproperty
  a_code: assert property (p_code) else $error("alarm code disagrees");
endmodule : pifs_supervisor

// ---- pifs_plant.sv ----
`timescale 1ns/1ps
module pifs_plant (
  input wire logic i_mclk,
  input wire logic [2:0] i_mode,
  input wire logic i_coil_drive,
  input wire logic i_discharge_en,
  input wire logic i_precharge_en,
  output logic o_pin_low,
  output logic o_closed,
  output logic o_charged,
  output logic o_discharged
);
  // Modes: 0 healthy, 1 driver shorted, 2 driver dead, 3 coil open, 4 welded, 5 no charge
  int lvl = 0;
  logic drv_d = 1'b0;
  always @(posedge i_mclk) begin
    drv_d <= i_coil_drive;
    if (i_precharge_en && i_mode != 3'h5 && lvl < 4) begin
      lvl <= lvl + 1;
    end else if (i_discharge_en && i_mode != 3'h4 && lvl > 0) begin
      lvl <= lvl - 1;
    end
  end
  assign o_pin_low = (i_mode == 3'h1) || (drv_d && i_mode != 3'h2);
  assign o_closed = (i_mode == 3'h4) || (o_pin_low && drv_d && i_mode != 3'h3);
  assign o_charged = (lvl == 4);
  assign o_discharged = (lvl == 0);
endmodule : pifs_plant

// ---- tb_pump_inverter_fault_supervisor.sv ----
`timescale 1ns/1ps
module tb_pump_inverter_fault_supervisor;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic key = 1'b0, self_f = 1'b0, pmem = 1'b0, phfb = 1'b0, cprot = 1'b0;
  logic phlo = 1'b0, phhi = 1'b0, diode = 1'b1, curnz = 1'b0, seat = 1'b0;
  logic ena = 1'b0, req = 1'b0, combi = 1'b0, seat_r = 1'b0, ev = 1'b0;
  logic [1:0] nom = 2'h0;
  logic [7:0] volt = 8'h30;
  logic [11:0] spd = 12'h000, pot = 12'h000, pmin = 12'h000, base;
  logic [2:0] pmode = 3'h0;
  logic pin_low, closed, charged, dis, coil, dis_en, pre_en, bridge, ign, inh, rstd;
  logic [17:0] alm;
  logic [4:0] code;
  logic restored = 1'b0;
  logic [15:0] lfsr_s = 16'h003b;
  int fail_count = 0;
  int checks_done = 0;
  int dis_cyc = 0, pre_cyc = 0, n_dis = 0, n_pre = 0;
  int exp_alm = 0;
  int pins[8] = '{0, 1, 3, 4, 8, 9, 11, 12};
  int modes[5] = '{4, 1, 2, 3, 5};
  int mbit[5] = '{17, 14, 15, 16, 7};
  logic [7:0] uv[4] = '{8'h0f, 8'h1e, 8'h22, 8'h28};
  logic [7:0] ov[4] = '{8'h41, 8'h73, 8'h7d, 8'h98};

  always #2 clk = ~clk;
  always @(posedge clk) if (rstd === 1'b1) restored <= 1'b1;
  always @(posedge clk) begin
    dis_cyc <= dis_cyc + int'(dis_en);
    pre_cyc <= pre_cyc + int'(pre_en);
  end

  pifs_supervisor #(.DISCH_TMO_CYC(20), .PRECH_TMO_CYC(20), .COIL_TMO_CYC(20),
    .CLOSE_TMO_CYC(20)) i_dut (
    .i_mclk(clk), .i_sys_rst(rst), .i_key_on(key), .i_selftest_fail(self_f),
    .i_param_mem_fault(pmem), .i_phase_fb_fault(phfb), .i_curr_prot_fault(cprot),
    .i_phase_voltage_low(phlo), .i_phase_voltage_high(phhi),
    .i_pot_return_diode_on(diode), .i_motor_curr_nonzero(curnz), .i_seat_sw(seat),
    .i_cap_charged(charged), .i_cap_discharged(dis),
    .i_contactor_coil_drive_pin_low(pin_low), .i_main_contactor_closed(closed),
    .i_pump_enable_sw(ena), .i_pump_req(req), .i_combi_mode(combi),
    .i_seat_remote(seat_r), .i_batt_nominal(nom), .i_batt_volt(volt),
    .i_enc_valid(ev), .i_enc_speed(spd), .i_pot_mv(pot), .i_pot_minimum_learn_mv(pmin),
    .o_coil_drive(coil), .o_discharge_en(dis_en), .o_precharge_en(pre_en),
    .o_bridge_en(bridge), .o_pump_ignore(ign), .o_run_inhibit(inh),
    .o_restore_defaults(rstd), .o_alarm(alm), .o_alarm_code(code));

  pifs_plant i_plant (.i_mclk(clk), .i_mode(pmode), .i_coil_drive(coil),
    .i_discharge_en(dis_en), .i_precharge_en(pre_en), .o_pin_low(pin_low),
    .o_closed(closed), .o_charged(charged), .o_discharged(dis));

  function automatic logic [15:0] lfsr();
    lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
    return lfsr_s;
  endfunction : lfsr

  function automatic logic [31:0] code_of(input int a);
    for (int i = 0; i < 18; i++) if (a[i]) return 32'(i + 1);
    return 32'h0;
  endfunction : code_of

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_alarm();
    chk("alarm", 32'(exp_alm), 32'(alm));
    chk("code", code_of(exp_alm), 32'(code));
  endtask : chk_alarm

  task automatic cycle_key();
    key = 1'b0;
    tick(6);
    exp_alm = 0;
    key = 1'b1;
    tick(90);
  endtask : cycle_key

  task automatic enc(input logic [11:0] s);
    spd = s;
    ev = 1'b1;
    tick(1);
    ev = 1'b0;
    tick(4);
  endtask : enc

  task automatic set_pin(input int i, input logic v);
    case (i)
      0: self_f = v;
      1: pmem = v;
      3: phfb = v;
      4: cprot = v;
      8: phlo = v;
      9: phhi = v;
      11: diode = !v;
      default: curnz = v;
    endcase
  endtask : set_pin

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    tick(10);
    rst = 1'b0;
    pmin = 12'h064 + 12'(lfsr() % 16'h07d0);
    cycle_key();
    chk("coil", 1, coil);
    chk_alarm();
    ena = 1'b1;
    tick(4);
    req = 1'b1;
    tick(6);
    chk("bridge", 1, bridge);
    base = 12'h100 + (lfsr() & 12'h3ff);
    enc(base);
    enc(base + 12'h028);
    chk_alarm();
    enc(base + 12'h051);
    exp_alm = 1 << 6;
    chk_alarm();
    chk("bridge", 0, bridge);
    req = 1'b0;
    ena = 1'b0;
    cycle_key();
    req = 1'b1;
    tick(6);
    exp_alm = 1 << 5;
    chk_alarm();
    req = 1'b0;
    tick(6);
    exp_alm = 0;
    chk_alarm();
    cycle_key();
    pot = pmin + 12'h3e7;
    tick(6);
    chk_alarm();
    pot = pmin + 12'h3e9;
    tick(6);
    exp_alm = 1 << 10;
    chk_alarm();
    chk("ignore", 1, ign);
    ena = 1'b1;
    tick(4);
    req = 1'b1;
    tick(6);
    chk("bridge", 0, bridge);
    req = 1'b0;
    ena = 1'b0;
    pot = pmin;
    tick(6);
    exp_alm = 0;
    chk_alarm();
    chk("ignore", 0, ign);
    cycle_key();
    foreach (pins[i]) begin
      set_pin(pins[i], 1'b1);
      tick(6);
      exp_alm = 1 << pins[i];
      chk_alarm();
      chk("inhibit", 1, inh);
      chk("coil", 32'(!exp_alm[pins[i]] || pins[i] inside {0, 1, 11}), coil);
      set_pin(pins[i], 1'b0);
      restored = 1'b0;
      cycle_key();
      chk("restore", 32'(pins[i] == 1), 32'(restored));
    end
    for (int n = 0; n < 4; n++) begin
      for (int k = 0; k < 4; k++) begin
        nom = 2'(n);
        volt = (k < 2) ? uv[n] - 8'(k) : ov[n] + 8'(k - 2);
        cycle_key();
        exp_alm = (k % 2 == 1) ? 4 : 0;
        chk_alarm();
        chk("coil", 32'(k % 2 == 0), coil);
      end
    end
    nom = 2'h0;
    volt = 8'h30;
    cycle_key();
    foreach (modes[i]) begin
      n_dis = dis_cyc;
      n_pre = pre_cyc;
      pmode = 3'(modes[i]);
      cycle_key();
      exp_alm = 1 << mbit[i];
      chk_alarm();
      chk("coil", 0, coil);
      chk("inhibit", 1, inh);
      if (modes[i] == 4) chk("discharge_cycles", 21, dis_cyc - n_dis);
      if (modes[i] == 5) chk("precharge_cycles", 21, pre_cyc - n_pre);
    end
    pmode = 3'h0;
    combi = 1'b1;
    cycle_key();
    chk("coil", 0, coil);
    chk_alarm();
    seat = 1'b1;
    tick(6);
    exp_alm = 1 << 13;
    chk_alarm();
    seat_r = 1'b1;
    tick(6);
    exp_alm = 0;
    chk_alarm();
    tally_and_finish();
  end
endmodule : tb_pump_inverter_fault_supervisor
